// ### common/ssra_regs.vh
// constants of the serial register access slave: command fields and widths
// assumes inclusion by bare name from the design files
`ifndef SSRA_REGS_VH
`define SSRA_REGS_VH
`define SSRA_BYTE_W 8
`define SSRA_BIT_CNT_W 3
`define SSRA_BIT_LAST 3'h7
`define SSRA_CMD_RW_BIT 0
`define SSRA_CMD_BANK_BIT 1
`define SSRA_CMD_HOLD_BIT 2
`define SSRA_CMD_RESET 8'h00
`define SSRA_PTR_RESET 8'h00
`define SSRA_SYNC_STAGES 2
`endif

// ### src/ssra_sync.v
// two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module ssra_sync #(
   parameter RESET_VAL = 1'b0
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire async_i,
   output reg sync_o
);
   reg meta_reg;
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= RESET_VAL;
         sync_o <= RESET_VAL;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ### src/ssra_cfg_bank.v
// configuration register bank: byte-wide writable registers with defaults
// assumes write strobe and index come from the controller on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "ssra_regs.vh"
module ssra_cfg_bank #(
   parameter NUM = 4,
   parameter IDX_W = 2,
   parameter [NUM*8-1:0] DEFAULTS = {NUM*8{1'b0}}
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire wr_i,
   input wire [IDX_W-1:0] idx_i,
   input wire [`SSRA_BYTE_W-1:0] wdata_i,
   output reg [NUM*8-1:0] cfg_o
);
   integer i;
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cfg_o <= DEFAULTS;
      else if (wr_i)
      begin
         for (i = 0; i < NUM; i = i + 1)
            if (idx_i == i[IDX_W-1:0])
               cfg_o[i*8 +: 8] <= wdata_i;
      end
   end
endmodule
`default_nettype wire

// ### src/ssra_slave.v
// serial register access slave: header, sequential byte access to two banks
// assumes system clock at least six times the serial clock; pins asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "ssra_regs.vh"
module ssra_slave #(
   parameter NUM_CFG = 4,
   parameter CFG_INDEX_BITS = 2,
   parameter NUM_STAT = 4,
   parameter STAT_INDEX_BITS = 2,
   parameter CPOL = 0,
   parameter CPHA = 0,
   parameter [NUM_CFG*8-1:0] CFG_DEFAULTS = {NUM_CFG*8{1'b0}}
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire sclk_i,
   input wire ss_n_i,
   input wire mosi_i,
   output reg miso_o,
   output reg miso_oe_o,
   output reg command_write_strobe_o,
   output reg addr_write_strobe_o,
   output reg cfg_write_strobe_o,
   output reg cfg_read_strobe_o,
   output reg stat_read_strobe_o,
   output reg [7:0] transfer_command_o,
   output reg [7:0] register_pointer_o,
   output wire [NUM_CFG*8-1:0] cfg_o,
   input wire [NUM_STAT*8-1:0] stat_i
);
   // ==========================================================
   // state codes
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_ADDR = 3'h2;
   localparam [2:0] ST_DATA = 3'h4;
   // sample on rising edge when polarity equals phase
   localparam SAMPLE_RISE = (CPOL == CPHA);

   // ==========================================================
   // synchronisers
   wire sclk_s;
   wire ss_n_s;
   wire mosi_s;
   ssra_sync #(.RESET_VAL(CPOL[0])) u_sync_sclk (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i(sclk_i),
      .sync_o(sclk_s)
   );
   ssra_sync #(.RESET_VAL(1'b1)) u_sync_ss (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i(ss_n_i),
      .sync_o(ss_n_s)
   );
   ssra_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i(mosi_i),
      .sync_o(mosi_s)
   );

   // ==========================================================
   // edge detection on synchronised samples
   reg sclk_d_reg;
   reg ss_d_reg;
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sclk_d_reg <= CPOL[0];
         ss_d_reg <= 1'b1;
      end
      else
      begin
         sclk_d_reg <= sclk_s;
         ss_d_reg <= ss_n_s;
      end
   end
   wire rise = sclk_s & ~sclk_d_reg;
   wire fall = ~sclk_s & sclk_d_reg;
   wire sample_edge = SAMPLE_RISE ? rise : fall;
   wire shift_edge = SAMPLE_RISE ? fall : rise;
   wire ss_start = ss_d_reg & ~ss_n_s;
   wire active = ~ss_n_s;

   // ==========================================================
   // sequencer
   reg [2:0] state_reg;
   reg [`SSRA_BIT_CNT_W-1:0] bit_cnt_reg;
   reg [6:0] shift_reg;
   reg [7:0] tx_reg;
   reg tx_first_reg;
   reg cfg_wr;
   wire [7:0] byte_in = {shift_reg, mosi_s};
   wire byte_done = active & sample_edge & (bit_cnt_reg == `SSRA_BIT_LAST);
   wire is_read = transfer_command_o[`SSRA_CMD_RW_BIT];
   wire is_stat = transfer_command_o[`SSRA_CMD_BANK_BIT];
   wire hold_ptr = transfer_command_o[`SSRA_CMD_HOLD_BIT];
   wire [CFG_INDEX_BITS-1:0] cfg_idx = register_pointer_o[CFG_INDEX_BITS-1:0];
   wire [STAT_INDEX_BITS-1:0] stat_idx = register_pointer_o[STAT_INDEX_BITS-1:0];
   wire [7:0] cfg_byte = cfg_o[cfg_idx*8 +: 8];
   wire [7:0] stat_byte = stat_i[stat_idx*8 +: 8];
   wire [7:0] rd_byte = is_stat ? stat_byte : cfg_byte;
   // pointer wraps inside the bank since only the index bits are kept
   wire [7:0] bank_mask = is_stat ? ((8'h01 << STAT_INDEX_BITS) - 8'h01)
                                  : ((8'h01 << CFG_INDEX_BITS) - 8'h01);
   wire [7:0] ptr_inc = (register_pointer_o + 8'h01) & bank_mask;

   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= ST_CMD;
         bit_cnt_reg <= {`SSRA_BIT_CNT_W{1'b0}};
         shift_reg <= 7'h00;
         tx_reg <= 8'h00;
         tx_first_reg <= 1'b0;
         transfer_command_o <= `SSRA_CMD_RESET;
         register_pointer_o <= `SSRA_PTR_RESET;
         miso_o <= 1'b0;
         miso_oe_o <= 1'b0;
         cfg_wr <= 1'b0;
         command_write_strobe_o <= 1'b0;
         addr_write_strobe_o <= 1'b0;
         cfg_write_strobe_o <= 1'b0;
         cfg_read_strobe_o <= 1'b0;
         stat_read_strobe_o <= 1'b0;
      end
      else
      begin
         // strobes default low so each lasts a single cycle
         command_write_strobe_o <= 1'b0;
         addr_write_strobe_o <= 1'b0;
         cfg_write_strobe_o <= 1'b0;
         cfg_read_strobe_o <= 1'b0;
         stat_read_strobe_o <= 1'b0;
         cfg_wr <= 1'b0;
         tx_first_reg <= 1'b0;
         if (!active || ss_start)
         begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= {`SSRA_BIT_CNT_W{1'b0}};
            miso_oe_o <= 1'b0;
         end
         else
         begin
            if (sample_edge)
            begin
               shift_reg <= byte_in[6:0];
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            // first read bit must be on the line before the first edge with phase 0
            if (tx_first_reg && !CPHA)
               miso_o <= tx_reg[7];
            else if (shift_edge && miso_oe_o)
            begin
               miso_o <= tx_reg[7];
               tx_reg <= {tx_reg[6:0], 1'b0};
            end
            if (byte_done)
            begin
               case (state_reg)
                  ST_CMD:
                  begin
                     transfer_command_o <= byte_in;
                     command_write_strobe_o <= 1'b1;
                     state_reg <= ST_ADDR;
                  end
                  ST_ADDR:
                  begin
                     register_pointer_o <= byte_in;
                     addr_write_strobe_o <= 1'b1;
                     state_reg <= ST_DATA;
                  end
                  ST_DATA:
                  begin
                     // status writes fall through as dummy bytes
                     if (!is_read && !is_stat)
                     begin
                        cfg_wr <= 1'b1;
                        cfg_write_strobe_o <= 1'b1;
                     end
                     if (is_read && !is_stat)
                        cfg_read_strobe_o <= 1'b1;
                     if (is_read && is_stat)
                        stat_read_strobe_o <= 1'b1;
                     if (!hold_ptr)
                        register_pointer_o <= ptr_inc;
                  end
                  default:
                     state_reg <= ST_CMD;
               endcase
            end
            else if (state_reg == ST_DATA && is_read && bit_cnt_reg == 3'h0 &&
                     !miso_oe_o)
            begin
               // load the addressed byte once the pointer has settled
               tx_reg <= rd_byte;
               tx_first_reg <= 1'b1;
               miso_oe_o <= 1'b1;
            end
            else if (state_reg == ST_DATA && is_read && byte_done == 1'b0 &&
                     bit_cnt_reg == 3'h0 && miso_oe_o && shift_edge)
            begin
               // reload next byte on the first shift edge of each byte
               miso_o <= rd_byte[7];
               tx_reg <= {rd_byte[6:0], 1'b0};
            end
         end
      end
   end

   // ==========================================================
   // configuration bank; write data is the byte just completed
   reg [7:0] wdata_reg;
   reg [CFG_INDEX_BITS-1:0] widx_reg;
   always @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wdata_reg <= 8'h00;
         widx_reg <= {CFG_INDEX_BITS{1'b0}};
      end
      else if (byte_done)
      begin
         wdata_reg <= byte_in;
         widx_reg <= cfg_idx;
      end
   end
   ssra_cfg_bank #(
      .NUM(NUM_CFG),
      .IDX_W(CFG_INDEX_BITS),
      .DEFAULTS(CFG_DEFAULTS)
   ) u_cfg (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .wr_i(cfg_wr),
      .idx_i(widx_reg),
      .wdata_i(wdata_reg),
      .cfg_o(cfg_o)
   );
   // a bank change only takes effect through a fresh header in a new frame
endmodule
`default_nettype wire

// ### dv/ssra_checker.sv
// checker: port-level properties of the serial register slave
// assumes one system clock domain and async active-low reset
`timescale 1ns/10ps
`default_nettype none
module ssra_checker #(
   parameter NUM_CFG = 4,
   parameter NUM_STAT = 4
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic sclk_i,
   input wire logic ss_n_i,
   input wire logic mosi_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic command_write_strobe_o,
   input wire logic addr_write_strobe_o,
   input wire logic cfg_write_strobe_o,
   input wire logic cfg_read_strobe_o,
   input wire logic stat_read_strobe_o,
   input wire logic [7:0] transfer_command_o,
   input wire logic [7:0] register_pointer_o,
   input wire logic [NUM_CFG*8-1:0] cfg_o,
   input wire logic [NUM_STAT*8-1:0] stat_i
);
   // ==========
   // properties
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   wire data_stb = cfg_write_strobe_o | cfg_read_strobe_o | stat_read_strobe_o;
   sequence s_cmd_done; command_write_strobe_o; endsequence
   sequence s_addr_quiet; !addr_write_strobe_o [*8]; endsequence
   property p_cmd_pulse; command_write_strobe_o |=> !command_write_strobe_o; endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe too long");
   property p_addr_pulse; addr_write_strobe_o |=> !addr_write_strobe_o; endproperty
   a_addr_pulse: assert property (p_addr_pulse) else $error("address strobe too long");
   property p_data_pulse; data_stb |=> !data_stb; endproperty
   a_data_pulse: assert property (p_data_pulse) else $error("data strobe too long");
   property p_hdr_order; s_cmd_done |=> s_addr_quiet; endproperty
   a_hdr_order: assert property (p_hdr_order) else $error("address byte too early");
   property p_wr_cfg; cfg_write_strobe_o |-> transfer_command_o[1:0] == 2'b00; endproperty
   a_wr_cfg: assert property (p_wr_cfg) else $error("write strobe wrong command");
   property p_rd_cfg; cfg_read_strobe_o |-> transfer_command_o[1:0] == 2'b01; endproperty
   a_rd_cfg: assert property (p_rd_cfg) else $error("config read wrong command");
   property p_rd_stat; stat_read_strobe_o |-> transfer_command_o[1:0] == 2'b11; endproperty
   a_rd_stat: assert property (p_rd_stat) else $error("status read wrong command");
   // select high takes three clocks through the synchroniser to release the line
   property p_oe_read; miso_oe_o |-> transfer_command_o[0] && !$past(ss_n_i, 3); endproperty
   a_oe_read: assert property (p_oe_read) else $error("output driven outside read");
   property p_oe_idle; ss_n_i [*8] |-> !miso_oe_o; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
   // the pointer moves on the same edge that raises the data strobe
   property p_hold; data_stb && transfer_command_o[2] |-> $stable(register_pointer_o); endproperty
   a_hold: assert property (p_hold) else $error("pointer moved while held");
   property p_advance;
      data_stb && !transfer_command_o[2] |-> register_pointer_o != $past(register_pointer_o);
   endproperty
   a_advance: assert property (p_advance) else $error("pointer did not advance");
endmodule
bind ssra_slave ssra_checker #(.NUM_CFG(NUM_CFG), .NUM_STAT(NUM_STAT)) i_ssra_checker (.*);
`default_nettype wire

// ### dv/ssra_master.sv
// serial bus master model, clock polarity 0 and phase 0, 80 ns bit period
// assumes the bench calls its tasks off the system clock edges
`timescale 1ns/10ps
`default_nettype none
module ssra_master (
   input wire logic miso_i,
   input wire logic miso_oe_i,
   output logic sclk_o,
   output logic ss_n_o,
   output logic mosi_o
);
   // ==========
   // bus tasks
   logic [7:0] rx;
   // released line shows the inverse so a stale value cannot pass
   wire line = miso_oe_i ? miso_i : ~miso_i;
   initial
   begin
      sclk_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic shift(input logic [7:0] tx, input int nb);
      for (int i = 7; i > 7 - nb; i--)
      begin
         mosi_o = tx[i];
         #40 sclk_o = 1'b1;
         rx = {rx[6:0], line};
         #40 sclk_o = 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] c, a, d0, d1, output logic [7:0] r0, r1);
      ss_n_o = 1'b0;
      #40 shift(c, 8);
      shift(a, 8);
      shift(d0, 8);
      r0 = rx;
      shift(d1, 8);
      r1 = rx;
      #40 ss_n_o = 1'b1;
      #200;
   endtask
   task automatic abort;
      ss_n_o = 1'b0;
      #40 shift(8'h00, 4);
      #40 ss_n_o = 1'b1;
      #200;
   endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the serial register slave, four regs per bank
// assumes the master model drives the serial pins
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam [31:0] DEF = 32'h5a3c0f81;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [31:0] stat_i = 32'hd4c3b2a1;
   wire sclk, ss_n, mosi, miso, oe, cws, aws, cfws, cfrs, srs;
   wire [7:0] cmd, ptr;
   wire [31:0] cfg;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   int n_wr = 0;
   int n_rd = 0;
   int n_st = 0;
   int n_hdr = 0;
   logic [7:0] r0, r1;
   always #2 clk_sys_i = ~clk_sys_i;
   ssra_slave #(.CFG_DEFAULTS(DEF)) i_ssra_slave (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe),
      .command_write_strobe_o(cws), .addr_write_strobe_o(aws), .cfg_write_strobe_o(cfws),
      .cfg_read_strobe_o(cfrs), .stat_read_strobe_o(srs), .transfer_command_o(cmd),
      .register_pointer_o(ptr), .cfg_o(cfg), .stat_i(stat_i));
   ssra_master i_ssra_master (.miso_i(miso), .miso_oe_i(oe), .sclk_o(sclk), .ss_n_o(ss_n),
      .mosi_o(mosi));
   // ==========
   // checking and closing
   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      n_wr <= n_wr + int'(cfws);
      n_rd <= n_rd + int'(cfrs);
      n_st <= n_st + int'(srs);
      n_hdr <= n_hdr + int'(cws) + int'(aws);
      if (cyc == 20000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   // ==========
   // scenarios
   task automatic t_write;
      int w;
      int h;
      w = n_wr;
      h = n_hdr;
      i_ssra_master.frame(8'hf8, 8'h03, 8'h11, 8'h22, r0, r1);
      check("cmd", cmd, 8'hf8);
      check("cfg", cfg, {8'h11, DEF[23:8], 8'h22});
      check("ptr", ptr, 8'h01);
      check("wr", n_wr - w, 2);
      check("hdr", n_hdr - h, 2);
   endtask
   task automatic t_read_hold;
      int r;
      r = n_rd;
      i_ssra_master.frame(8'h05, 8'h00, 8'h00, 8'h00, r0, r1);
      check("r0", r0, 8'h22);
      check("r1", r1, 8'h22);
      check("ptr", ptr, 8'h00);
      check("rd", n_rd - r, 2);
   endtask
   task automatic t_stat;
      int s;
      s = n_st;
      i_ssra_master.frame(8'h03, 8'h03, 8'h00, 8'h00, r0, r1);
      check("s0", r0, 8'hd4);
      check("s1", r1, 8'ha1);
      check("st", n_st - s, 2);
   endtask
   task automatic t_stat_write;
      int w;
      w = n_wr;
      i_ssra_master.frame(8'h02, 8'h00, 8'hee, 8'hee, r0, r1);
      check("cfg", cfg, {8'h11, DEF[23:8], 8'h22});
      check("wr", n_wr - w, 0);
   endtask
   task automatic t_abort;
      i_ssra_master.abort();
      i_ssra_master.frame(8'h01, 8'h01, 8'h00, 8'h00, r0, r1);
      check("cmd", cmd, 8'h01);
      check("r0", r0, DEF[15:8]);
      check("r1", r1, DEF[23:16]);
      check("oe", oe, 1'b0);
   endtask
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      #1;
      check("cfg", cfg, DEF);
      check("ptr", ptr, 8'h00);
      check("oe", oe, 1'b0);
      t_write();
      t_read_hold();
      t_stat();
      t_stat_write();
      t_abort();
      give_verdict();
   end
endmodule
`default_nettype wire
